// ===== rtl/oss_clock_switch.sv
// Oscillator switch, ready status, fail-safe and idle control with Wishbone slave
//
// Functional notes
// RULE1: Hold set: ready new oscillator interrupts, no switch
// RULE2: New-ready flag: switch pending and oscillator ready
// RULE3: Unheld: flag one clock late, switch next
// RULE4: PLL ready needs enable, source ready, lock
// RULE5: Four-times PLL on external modes, 64 MHz
// RULE6: Fail-safe compares main clock against slow reference
// RULE7: Clock failure falls back to internal oscillator
// RULE8: HF internal 1-64 MHz; slow oscillators 31 kHz
// RULE9: Idle stops core clock, peripherals keep running
// RULE10: Hardware clears hold; ready needs enable, stable
// RULE11: Switch-complete flag set when current equals requested
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module oss_clock_switch
  import oss_pkg::*;
(
  input  wire logic                 CLK,            // Bus clock, 20 MHz
  input  wire logic                 RESET_N,        // Synchronous reset
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [7:0]           WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  input  wire logic [oss_pkg::NUM_OSC-1:0] OSC_STABLE, // Analog stable flags
  input  wire logic                 PLL_LOCK,       // PLL lock indication
  input  wire logic                 MAIN_CLK_TICK,  // Activity of main clock
  input  wire logic                 LF_REF_TICK,    // Slow reference tick
  output logic [2:0]                CLK_SEL,        // System clock source
  output logic                      PLL_EN,         // PLL running
  output logic [oss_pkg::NUM_OSC-1:0] OSC_EN,       // Oscillator enables
  output logic [3:0]                HF_FREQ_CODE,   // HF internal frequency
  output logic                      SEC_OSC_HIGH_POWER,
  output logic                      CORE_CLK_EN,    // Core clock gate
  output logic                      PERIPH_CLK_EN,  // Peripheral clock gate
  output logic                      IRQ             // Level interrupt
);
  import oss_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]         ctrl_r;          // Hold and power-mode bits
  logic [2:0]         req_sel_r;       // Requested source
  logic [2:0]         cur_sel_r;       // Running source
  logic               nrdy_r;          // New oscillator ready flag
  logic [7:0]         misc_r;          // Misc control byte
  logic               idle_r;          // Idle in force
  logic [NUM_OSC-1:0] osc_en_r;        // Enables driven out
  logic [NUM_OSC-1:0] rdy_r;           // Per-oscillator ready
  logic               pll_rdy_r;       // PLL usable
  logic               main_seen_r;     // Main clock seen this window
  logic [2:0]         irq_st_r;        // Sticky events
  logic [2:0]         irq_mask_r;      // Event mask
  logic               ack_r;           // Bus acknowledge
  logic [31:0]        dat_r;           // Read data
  logic               pll_out_r;       // PLL enable out
  logic               core_en_r;       // Core gate out
  logic               irq_r;           // Interrupt out
  logic               periph_en_r;     // Peripheral gate out, never dropped

  logic               wr;              // Write takes effect now
  logic               pending;         // Switch in progress
  logic               new_rdy;         // Requested source usable
  logic               release_wr;      // Software releases held switch
  logic               fire;            // Switch happens this edge
  logic               fail;            // Main clock lost
  logic               held_evt;        // Switch became held
  logic [2:0]         evt;             // Event pulses
  logic [3:0]         hf_code;         // Clamped HF code
  oss_ready_type      stat;            // Status byte view

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Ready of a source; invalid codes never become ready
  function automatic logic src_ready(input logic [2:0] sel,
                                     input logic [NUM_OSC-1:0] rdy,
                                     input logic pll_on,
                                     input logic pll_ok);
    if (sel >= 3'(NUM_OSC)) begin
      src_ready = 1'b0;
    end else if (sel == SEL_EXT && pll_on) begin
      src_ready = rdy[SEL_EXT] & pll_ok;
    end else begin
      src_ready = rdy[sel];
    end
  endfunction

  // HF code to frequency in MHz, used by the range check
  function automatic logic [6:0] hf_mhz(input logic [3:0] code);
    case (code)
      4'h0:    hf_mhz = 7'd1;
      4'h1:    hf_mhz = 7'd2;
      4'h2:    hf_mhz = 7'd4;
      4'h3:    hf_mhz = 7'd8;
      4'h4:    hf_mhz = 7'd12;
      4'h5:    hf_mhz = 7'd16;
      4'h6:    hf_mhz = 7'd32;
      4'h7:    hf_mhz = 7'd48;
      default: hf_mhz = 7'd64;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  always_comb begin
    // Writes land on the edge where the master sees ack
    wr         = WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0] & ack_r;
    release_wr = wr & (WB_ADR_I == ADR_CTRL) & WB_DAT_I[CTRL_RELEASE];
    pending    = (req_sel_r != cur_sel_r);
    new_rdy    = pending & src_ready(req_sel_r, rdy_r, misc_r[MISC_PLL_EN],
                                     pll_rdy_r);                    // RULE2
    // Flag is one clock behind ready; switch if unheld or on a release write
    fire       = nrdy_r & pending & (~ctrl_r[CTRL_HOLD] | release_wr); // RULE1 RULE3
    // No main activity in a whole reference window while it runs
    fail       = misc_r[MISC_FS_EN] & LF_REF_TICK & rdy_r[SEL_LF]
               & ~main_seen_r & (cur_sel_r == SEL_EXT);             // RULE6
    held_evt   = new_rdy & ~nrdy_r & ctrl_r[CTRL_HOLD];             // RULE1
    evt        = {fire, fail, held_evt};
    hf_code    = (misc_r[7:4] > HF_CODE_MAX) ? HF_CODE_MAX : misc_r[7:4]; // RULE8
    stat       = '{external_osc_ready:       rdy_r[SEL_EXT],
                   high_freq_internal_ready: rdy_r[SEL_HF],
                   mid_freq_internal_ready:  rdy_r[SEL_MF],
                   low_freq_internal_ready:  rdy_r[SEL_LF],
                   secondary_osc_ready:      rdy_r[SEL_SEC],
                   converter_osc_ready:      rdy_r[SEL_ADC],
                   unused:                   1'b0,
                   pll_ready:                pll_rdy_r};
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  // Unmapped addresses ack and read zero
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= WB_CYC_I & WB_STB_I & ~ack_r;
      if (WB_CYC_I & WB_STB_I & ~ack_r) begin
        case (WB_ADR_I)
          ADR_CTRL: dat_r <= {24'h0, ctrl_r[7:6], 1'b0, ~pending, nrdy_r,
                              3'h0};                                 // RULE11
          ADR_REQ:  dat_r <= {29'h0, req_sel_r};
          ADR_CUR:  dat_r <= {29'h0, cur_sel_r};
          ADR_STAT: dat_r <= {24'h0, stat};
          ADR_IRQ:  dat_r <= {29'h0, irq_st_r};
          ADR_MASK: dat_r <= {29'h0, irq_mask_r};
          ADR_MISC: dat_r <= {24'h0, misc_r[7:2], idle_r, misc_r[0]};
          default:  dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Switch control and hold
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_r <= CTRL_RST;
    end else if (wr && WB_ADR_I == ADR_CTRL) begin
      // Only hold and power mode are writable; the releasing write must not
      // re-arm hold, or the next switch would stall unexpectedly
      ctrl_r <= {WB_DAT_I[CTRL_HOLD] & ~(fire & ctrl_r[CTRL_HOLD]),
                 WB_DAT_I[CTRL_SPWR], 6'h00};                        // RULE10
    end else if (fire) begin
      ctrl_r[CTRL_HOLD] <= 1'b0;                                     // RULE10
    end
  end

  // Requested and current selection; fail-safe overrides both
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      req_sel_r <= SEL_HF;
      cur_sel_r <= SEL_HF;
    end else if (fail) begin
      req_sel_r <= SEL_HF;                                           // RULE7
      cur_sel_r <= SEL_HF;                                           // RULE7
    end else begin
      if (wr && WB_ADR_I == ADR_REQ) begin
        req_sel_r <= WB_DAT_I[2:0];
      end
      if (fire) begin
        cur_sel_r <= req_sel_r;                                      // RULE3
      end
    end
  end

  // Ready flag lags readiness by one clock and drops on the switch
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      nrdy_r <= 1'b0;
    end else begin
      nrdy_r <= new_rdy & ~fire & ~fail;                             // RULE2 RULE3
    end
  end

  // ----------------------------------------------------------------
  // Misc control and idle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      misc_r <= MISC_RST;
    end else if (wr && WB_ADR_I == ADR_MISC) begin
      misc_r <= WB_DAT_I[7:0];
    end
  end

  // Idle ends on any pending interrupt, the usual wake source
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      idle_r <= 1'b0;
    end else if (irq_r) begin
      idle_r <= 1'b0;
    end else if (wr && WB_ADR_I == ADR_MISC && WB_DAT_I[MISC_IDLE]) begin
      idle_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables and ready flags
  // ----------------------------------------------------------------
  // A source runs while selected or requested; the slow reference
  // also runs while the monitor needs it
  for (genvar i = 0; i < NUM_OSC; i++) begin : g_osc
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        osc_en_r[i] <= 1'b0;
        rdy_r[i]    <= 1'b0;
      end else begin
        osc_en_r[i] <= (cur_sel_r == 3'(i)) | (req_sel_r == 3'(i))
                     | ((3'(i) == SEL_LF) & misc_r[MISC_FS_EN]);
        rdy_r[i]    <= osc_en_r[i] & OSC_STABLE[i];                  // RULE10
      end
    end
  end

  // PLL only serves the external source
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pll_out_r <= 1'b0;
      pll_rdy_r <= 1'b0;
    end else begin
      pll_out_r <= misc_r[MISC_PLL_EN]
                 & ((req_sel_r == SEL_EXT) | (cur_sel_r == SEL_EXT)); // RULE5
      pll_rdy_r <= pll_out_r & rdy_r[SEL_EXT] & PLL_LOCK;            // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Fail-safe window
  // ----------------------------------------------------------------
  // A tick in the same cycle as the reference opens the next window
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      main_seen_r <= 1'b0;
    end else if (LF_REF_TICK) begin
      main_seen_r <= MAIN_CLK_TICK;                                  // RULE6
    end else if (MAIN_CLK_TICK) begin
      main_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_st_r   <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      if (wr && WB_ADR_I == ADR_IRQ) begin
        irq_st_r <= (irq_st_r & ~WB_DAT_I[2:0]) | evt;
      end else begin
        irq_st_r <= irq_st_r | evt;
      end
      if (wr && WB_ADR_I == ADR_MASK) begin
        irq_mask_r <= WB_DAT_I[2:0];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_r       <= 1'b0;
      core_en_r   <= 1'b1;
      periph_en_r <= 1'b1;
    end else begin
      irq_r       <= |(irq_st_r & irq_mask_r);
      core_en_r   <= ~idle_r;                                        // RULE9
      periph_en_r <= 1'b1;                                           // RULE9
    end
  end

  assign WB_ACK_O           = ack_r;
  assign WB_DAT_O           = dat_r;
  assign CLK_SEL            = cur_sel_r;
  assign PLL_EN             = pll_out_r;
  assign OSC_EN             = osc_en_r;
  assign HF_FREQ_CODE       = misc_r[7:4];
  assign SEC_OSC_HIGH_POWER = ctrl_r[CTRL_SPWR];
  assign CORE_CLK_EN        = core_en_r;
  assign PERIPH_CLK_EN      = periph_en_r;                           // RULE9
  assign IRQ                = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hold_blocks_switch: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE1
    (nrdy_r && ctrl_r[CTRL_HOLD] && !release_wr && !fail) |=> $stable(cur_sel_r))
    else $error("held switch completed");
  a_hold_raises_evt: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE1
    held_evt |=> irq_st_r[EVT_HELD])
    else $error("held switch gave no event");
  a_nrdy_pending: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE2
    nrdy_r |-> ($past(pending) && $past(src_ready(req_sel_r, rdy_r,
                misc_r[MISC_PLL_EN], pll_rdy_r))))
    else $error("new ready flag without ready source");
  a_switch_next: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE3
    (new_rdy && !ctrl_r[CTRL_HOLD] && !fail && !wr) ##1 (!fail && !wr)
      |=> (cur_sel_r == $past(req_sel_r, 2)) && !nrdy_r)
    else $error("unheld switch not done two clocks after ready");
  a_pll_ready: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE4
    pll_rdy_r |-> $past(pll_out_r && rdy_r[SEL_EXT] && PLL_LOCK))
    else $error("pll ready without its causes");
  a_pll_ext_only: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE5
    PLL_EN |-> $past(req_sel_r == SEL_EXT || cur_sel_r == SEL_EXT))
    else $error("pll on without external source");
  a_fail_fallback: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE6
    fail |=> (CLK_SEL == SEL_HF) && irq_st_r[EVT_FAIL])                 // RULE7
    else $error("no fallback after clock loss");
  a_hf_range: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE8
    (hf_mhz(hf_code) >= 7'(HF_MIN_MHZ)) && (hf_mhz(hf_code) <= 7'(HF_MAX_MHZ)))
    else $error("hf frequency out of range");
  a_idle_core: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE9
    (idle_r && !irq_r) ##1 idle_r |=> !CORE_CLK_EN && PERIPH_CLK_EN)
    else $error("core clock not gated in idle");
  a_ready_enabled: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE10
    rdy_r[SEL_HF] |-> $past(osc_en_r[SEL_HF] && OSC_STABLE[SEL_HF]))
    else $error("ready without enable");
  a_done_flag: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE11
    (WB_CYC_I && WB_STB_I && !ack_r && WB_ADR_I == ADR_CTRL)
      |=> dat_r[CTRL_DONE] == ($past(req_sel_r) == $past(cur_sel_r)))
    else $error("switch complete flag wrong");

endmodule // oss_clock_switch

// ===== rtl/oss_pkg.sv
// Package of constants and types for the oscillator switch and status block
package oss_pkg;
  // ----------------------------------------------------------------
  // Clock and frequency figures
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;    // System bus clock
  localparam int PLL_MULT        = 4;           // PLL factor on external modes
  localparam int SYS_MAX_MHZ     = 64;          // Highest system clock
  localparam int HF_MIN_MHZ      = 1;           // High-freq internal range floor
  localparam int HF_MAX_MHZ      = 64;          // High-freq internal range ceiling
  localparam int SLOW_OSC_KHZ    = 31;          // Low-freq internal and secondary
  localparam int SWITCH_DELAY_CYC = 1;          // New-ready flag to switch, in clocks
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;      // clock_switch_control
  localparam logic [7:0] ADR_REQ  = 8'h04;      // requested_clock_select
  localparam logic [7:0] ADR_CUR  = 8'h08;      // current_clock_select
  localparam logic [7:0] ADR_STAT = 8'h0c;      // oscillator_ready_status
  localparam logic [7:0] ADR_IRQ  = 8'h10;      // Sticky event status
  localparam logic [7:0] ADR_MASK = 8'h14;      // Event mask
  localparam logic [7:0] ADR_MISC = 8'h18;      // Fail-safe, idle, PLL, HF code
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_HOLD    = 7;              // switch_hold
  localparam int CTRL_SPWR    = 6;              // secondary_osc_power_mode
  localparam int CTRL_DONE    = 4;              // switch_complete_flag
  localparam int CTRL_NRDY    = 3;              // new_osc_ready_flag
  localparam int CTRL_RELEASE = 0;              // Write 1 to release a held switch
  localparam int MISC_FS_EN   = 0;              // Fail-safe monitor enable
  localparam int MISC_IDLE    = 1;              // Enter idle
  localparam int MISC_PLL_EN  = 2;              // PLL enable
  localparam int MISC_HF_LSB  = 4;              // HF frequency code, 4 bits
  localparam int EVT_HELD     = 0;              // Switch held event
  localparam int EVT_FAIL     = 1;              // Main clock failure event
  localparam int EVT_DONE     = 2;              // Switch completed event
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [3:0] HF_CODE_MAX = 4'h8;    // Highest legal HF code
  // ----------------------------------------------------------------
  // Oscillator selection codes, also the ready vector index
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_EXT = 3'h0;        // external_osc
  localparam logic [2:0] SEL_HF  = 3'h1;        // high_freq_internal_osc
  localparam logic [2:0] SEL_MF  = 3'h2;        // mid_freq_internal_osc
  localparam logic [2:0] SEL_LF  = 3'h3;        // low_freq_internal_osc
  localparam logic [2:0] SEL_SEC = 3'h4;        // secondary_osc
  localparam logic [2:0] SEL_ADC = 3'h5;        // Converter oscillator
  localparam int NUM_OSC = 6;
  // ----------------------------------------------------------------
  // Carrier for the ready status byte
  // ----------------------------------------------------------------
  typedef struct packed {
    logic external_osc_ready;
    logic high_freq_internal_ready;
    logic mid_freq_internal_ready;
    logic low_freq_internal_ready;
    logic secondary_osc_ready;
    logic converter_osc_ready;
    logic unused;
    logic pll_ready;
  } oss_ready_type;
endpackage

// ===== verif/tb.sv
// Self-checking bench for the oscillator switch and status block
`timescale 1ns/1ps
module tb;
  import oss_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk, reset_n, cyc, stb, we, ack;      // Clock, reset, bus handshake
  logic [7:0]  adr;                                  // Byte address
  logic [3:0]  sel;                                  // Byte enables
  logic [31:0] dat_i, dat_o;                         // Bus data
  logic [5:0]  osc_stable, osc_en;                   // Analog flags, enables
  logic        pll_lock, main_tick, ref_tick;        // Monitor inputs
  logic [2:0]  clk_sel;                              // Running source
  logic [3:0]  hf_code;                              // HF frequency code
  logic        pll_en, sec_hp, core_en, per_en, irq; // Gates and interrupt
  int          err_count, n_checks;                  // Mismatches, comparisons
  logic [7:0]  q;                                    // Last read byte

  oss_clock_switch i_oss_clock_switch (.CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .OSC_STABLE(osc_stable), .PLL_LOCK(pll_lock),
    .MAIN_CLK_TICK(main_tick), .LF_REF_TICK(ref_tick), .CLK_SEL(clk_sel), .PLL_EN(pll_en),
    .OSC_EN(osc_en), .HF_FREQ_CODE(hf_code), .SEC_OSC_HIGH_POWER(sec_hp),
    .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(per_en), .IRQ(irq));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Byte comparison; flags are passed zero extended
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; ack is read before the edge's updates land,
  // and only the watchdog ends a wait that never sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  // Bounded waits; a timeout shows up as a mismatch
  task automatic wait_sel(input logic [2:0] c);
    int n;
    n = 0;
    while (clk_sel !== c && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({5'h0, clk_sel}, {5'h0, c});
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, irq}, {7'h0, v});
  endtask
  task automatic pulse_ref();
    @(posedge clk);
    ref_tick <= 1'b1;
    @(posedge clk);
    ref_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    repeat (3) @(posedge clk);
    rd(ADR_CTRL, 8'h10);
    rd(ADR_REQ, 8'h01);
    rd(ADR_CUR, 8'h01);
    rd(ADR_STAT, 8'h40);
    rd(8'h1c, 8'h00);
    wb(1'b1, ADR_CUR, 8'h05);
    rd(ADR_CUR, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h40);
    rd(ADR_CTRL, 8'h50);
    chk({7'h0, sec_hp}, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h00);
    $display("reset test done");
  endtask
  // Unheld switch completes by itself and posts the done event
  task automatic t_switch();
    wb(1'b1, ADR_REQ, 8'h02);
    wait_sel(3'h2);
    rd(ADR_CTRL, 8'h10);
    rd(ADR_IRQ, 8'h04);
    wb(1'b1, ADR_IRQ, 8'h07);
    rd(ADR_IRQ, 8'h00);
    $display("switch test done");
  endtask
  // Held switch raises the interrupt and waits for release
  task automatic t_hold();
    wb(1'b1, ADR_MASK, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h80);
    wb(1'b1, ADR_REQ, 8'h03);
    wait_irq(1'b1);
    rd(ADR_CTRL, 8'h88);
    chk({5'h0, clk_sel}, 8'h02);
    rd(ADR_IRQ, 8'h01);
    wb(1'b1, ADR_CTRL, 8'h81);
    wait_sel(3'h3);
    rd(ADR_CTRL, 8'h10);
    wb(1'b1, ADR_IRQ, 8'h07);
    wait_irq(1'b0);
    $display("hold test done");
  endtask
  // Target not stable: no ready flag, no switch
  task automatic t_not_ready();
    wb(1'b1, ADR_REQ, 8'h04);
    repeat (6) @(posedge clk);
    rd(ADR_CTRL, 8'h00);
    chk({2'h0, osc_en}, 8'h18);
    chk({5'h0, clk_sel}, 8'h03);
    osc_stable[4] <= 1'b1;
    wait_sel(3'h4);
    rd(ADR_STAT, 8'h08);
    $display("not ready test done");
  endtask
  // External with PLL waits for lock
  task automatic t_pll();
    wb(1'b1, ADR_MISC, 8'h04);
    wb(1'b1, ADR_REQ, 8'h00);
    repeat (8) @(posedge clk);
    chk({5'h0, clk_sel}, 8'h04);
    rd(ADR_STAT, 8'h88);
    chk({7'h0, pll_en}, 8'h01);
    pll_lock <= 1'b1;
    wait_sel(3'h0);
    rd(ADR_STAT, 8'h81);
    $display("pll test done");
  endtask
  // Main clock stops: fall back to the internal source
  task automatic t_failsafe();
    main_tick <= 1'b1;
    wb(1'b1, ADR_MISC, 8'h05);
    pulse_ref();
    pulse_ref();
    chk({5'h0, clk_sel}, 8'h00);
    main_tick <= 1'b0;
    pulse_ref();
    pulse_ref();
    wait_sel(3'h1);
    rd(ADR_REQ, 8'h01);
    wb(1'b0, ADR_IRQ, 8'h00);
    chk(q & 8'h02, 8'h02);
    $display("fail-safe test done");
  endtask
  // Idle stops only the core; an unmasked event wakes it
  task automatic t_idle();
    wb(1'b1, ADR_IRQ, 8'h07);
    wb(1'b1, ADR_MASK, 8'h00);
    wb(1'b1, ADR_MISC, 8'h32);
    repeat (3) @(posedge clk);
    chk({7'h0, core_en}, 8'h00);
    chk({7'h0, per_en}, 8'h01);
    chk({4'h0, hf_code}, 8'h03);
    wb(1'b1, ADR_MASK, 8'h04);
    wb(1'b1, ADR_REQ, 8'h02);
    wait_irq(1'b1);
    repeat (3) @(posedge clk);
    chk({7'h0, core_en}, 8'h01);
    rd(ADR_MISC, 8'h30);
    $display("idle test done");
  endtask
  // ------------------------------------------------------------
  // Verdict and sequencing
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles; this cuts off a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
  // Secondary oscillator starts unstable for the not-ready case
  initial begin
    {cyc, stb, we, pll_lock, main_tick, ref_tick} = 6'h00;
    adr = 8'h00;
    sel = 4'hf;
    dat_i = 32'h0;
    osc_stable = 6'h2f;
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_switch();
    t_hold();
    t_not_ready();
    t_pll();
    t_failsafe();
    t_idle();
    wrap_up();
  end
endmodule // tb
